// ---- cursor_column_pkg.sv ----
// Constants for the cursor column address block: counter limits, decodes and register map.
// Assumes a 32-bit APB register bus and one 50 MHz system clock.
package cursor_column_pkg;

  // Counter widths.
  localparam int COL_WIDTH = 7;
  localparam int ROW_WIDTH = 5;

  // Column and row limits.
  localparam logic [6:0] COL_FIRST = 7'h00;
  localparam logic [6:0] COL_LAST = 7'h49;
  localparam logic [4:0] ROW_FIRST = 5'h00;
  localparam logic [4:0] ROW_LAST = 5'h1A;

  // Bit of the column count that starts the end-of-line tone.
  localparam int TONE_BIT = 6;

  // Reset values.
  localparam logic [6:0] COL_RESET = 7'h00;
  localparam logic [4:0] ROW_RESET = 5'h00;
  localparam logic [31:0] CONTROL_RESET = 32'h00000000;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COMMAND = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SAMPLE = 8'h0C;

  // Control register fields.
  localparam int CTRL_STEP_INHIBIT = 0;
  localparam int CTRL_KEY_INHIBIT = 1;

  // Command register fields; writing a one starts the action once.
  localparam int CMD_STEP_FORWARD = 0;
  localparam int CMD_STEP_BACKWARD = 1;
  localparam int CMD_CLEAR = 2;

  // Status register fields.
  localparam int STAT_COL_LSB = 0;
  localparam int STAT_ROW_LSB = 8;
  localparam int STAT_AT_FIRST = 16;
  localparam int STAT_AT_LAST = 17;
  localparam int STAT_ROW_FIRST = 18;
  localparam int STAT_ROW_LAST = 19;
  localparam int STAT_HOME = 20;

  // Sample register fields.
  localparam int SAMP_COL_LSB = 0;
  localparam int SAMP_ROW_LSB = 8;

endpackage

// ---- cursor_column_address_logic.sv ----
// Cursor column counter of a character terminal, with its row counter, decodes and APB registers.
// Assumes all command inputs are synchronous one-cycle or level signals on clock.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module cursor_column_address_logic (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer commands and timing.
  input wire logic seq_col_forward,
  input wire logic seq_col_backward,
  input wire logic phase_three_tick,
  input wire logic sequencer_step_four,
  input wire logic col_clear_n,
  // Keyboard and decision logic moves.
  input wire logic key_col_right,
  input wire logic key_col_left,
  // Host link.
  input wire logic host_col_advance,
  input wire logic host_step_strobe,
  input wire logic host_col_load_strobe,
  // Preset from the stored coincidence value.
  input wire logic coin_transfer_strobe,
  input wire logic [6:0] col_preset_bits,
  // Refresh logic.
  input wire logic refresh_start,
  // Counter outputs.
  output logic [6:0] cursor_col_count,
  output logic [6:0] cursor_col_count_n,
  output logic [4:0] cursor_row_count,
  output logic [6:0] sampled_col,
  output logic [4:0] sampled_row,
  // Decodes and strobes.
  output logic col_at_first,
  output logic col_at_last,
  output logic row_at_first,
  output logic row_at_last,
  output logic home,
  output logic tone_trigger,
  output logic count_up_enable,
  output logic count_down_enable,
  output logic step_pulse,
  output logic wrap_load,
  output logic row_inc_req,
  output logic row_dec_req
);

  logic [31:0] control;
  logic host_strobe_prev;
  logic cmd_forward;
  logic cmd_backward;
  logic cmd_clear;

  logic bus_write;
  logic bus_setup;
  logic host_step;
  logic seq_fwd_step;
  logic seq_back_step;
  logic key_fwd_step;
  logic key_back_step;
  logic next_step_up;
  logic next_step_down;
  logic next_step;
  logic next_wrap_up;
  logic next_wrap_down;
  logic preset_load;
  logic clear_col;
  logic [6:0] next_col;
  logic [4:0] next_row;
  logic [31:0] status_word;
  logic [31:0] read_word;
  logic read_hit;

  // Bus phases: an access completes on the edge where pready is sampled high.
  assign bus_setup = psel && !penable && !pready;
  assign bus_write = psel && penable && pready && pwrite;

  // Step sources. Host strobe is taken on its rising edge.
  assign host_step = host_col_advance && host_step_strobe && !host_strobe_prev;
  assign seq_fwd_step = (seq_col_forward || cmd_forward) && phase_three_tick;
  assign seq_back_step = (seq_col_backward || cmd_backward) && phase_three_tick;
  assign key_fwd_step = key_col_right && sequencer_step_four && !col_at_last;
  assign key_back_step = key_col_left && sequencer_step_four && !col_at_first;

  always_comb begin
    next_step_up = 1'b0;
    next_step_down = 1'b0;
    if (!control[cursor_column_pkg::CTRL_STEP_INHIBIT]) begin
      next_step_up = seq_fwd_step || host_step;
      next_step_down = seq_back_step;
      if (!control[cursor_column_pkg::CTRL_KEY_INHIBIT]) begin
        next_step_up = next_step_up || key_fwd_step;
        next_step_down = next_step_down || key_back_step;
      end
    end
    // A forward and backward step together cancel.
    if (next_step_up && next_step_down) begin
      next_step_up = 1'b0;
      next_step_down = 1'b0;
    end
  end

  assign next_step = next_step_up || next_step_down;
  // Keyboard steps never reach a wrap because they are blocked at the ends.
  assign next_wrap_up = next_step_up && col_at_last;
  assign next_wrap_down = next_step_down && col_at_first;

  assign clear_col = !col_clear_n || cmd_clear;
  assign preset_load = host_col_load_strobe || coin_transfer_strobe;

  // Next column: clear beats preset, preset beats stepping.
  always_comb begin
    next_col = cursor_col_count;
    if (clear_col) begin
      next_col = cursor_column_pkg::COL_FIRST;
    end else if (preset_load) begin
      next_col = ~col_preset_bits;
    end else if (next_wrap_up) begin
      next_col = cursor_column_pkg::COL_FIRST;
    end else if (next_wrap_down) begin
      next_col = cursor_column_pkg::COL_LAST;
    end else if (next_step_up) begin
      next_col = cursor_col_count + 7'h01;
    end else if (next_step_down) begin
      next_col = cursor_col_count - 7'h01;
    end
  end

  // Next row: moved only by column wrap and held at its ends.
  always_comb begin
    next_row = cursor_row_count;
    if (!clear_col && !preset_load) begin
      if (next_wrap_up && cursor_row_count != cursor_column_pkg::ROW_LAST) begin
        next_row = cursor_row_count + 5'h01;
      end else if (next_wrap_down && cursor_row_count != cursor_column_pkg::ROW_FIRST) begin
        next_row = cursor_row_count - 5'h01;
      end
    end
  end

  // Column counter with true and inverted forms.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cursor_col_count <= cursor_column_pkg::COL_RESET;
      cursor_col_count_n <= ~cursor_column_pkg::COL_RESET;
    end else begin
      cursor_col_count <= next_col;
      cursor_col_count_n <= ~next_col;
    end
  end

  // Row counter.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cursor_row_count <= cursor_column_pkg::ROW_RESET;
    end else begin
      cursor_row_count <= next_row;
    end
  end

  // Decodes follow the counters in the same cycle they change.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      col_at_first <= 1'b1;
      col_at_last <= 1'b0;
      row_at_first <= 1'b1;
      row_at_last <= 1'b0;
      home <= 1'b1;
      tone_trigger <= 1'b0;
    end else begin
      col_at_first <= next_col == cursor_column_pkg::COL_FIRST;
      col_at_last <= next_col == cursor_column_pkg::COL_LAST;
      row_at_first <= next_row == cursor_column_pkg::ROW_FIRST;
      row_at_last <= next_row == cursor_column_pkg::ROW_LAST;
      home <= (next_col == cursor_column_pkg::COL_FIRST)
        && (next_row == cursor_column_pkg::ROW_FIRST);
      tone_trigger <= next_col[cursor_column_pkg::TONE_BIT];
    end
  end

  // Step strobes are one-cycle pulses marking the edge the counter moved.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      step_pulse <= 1'b0;
      count_up_enable <= 1'b0;
      count_down_enable <= 1'b0;
      wrap_load <= 1'b0;
      row_inc_req <= 1'b0;
      row_dec_req <= 1'b0;
    end else begin
      step_pulse <= next_step && !clear_col && !preset_load;
      count_up_enable <= next_step_up && !clear_col && !preset_load;
      count_down_enable <= next_step_down && !clear_col && !preset_load;
      wrap_load <= (next_wrap_up || next_wrap_down) && !clear_col && !preset_load;
      row_inc_req <= next_wrap_up && !clear_col && !preset_load;
      row_dec_req <= next_wrap_down && !clear_col && !preset_load;
    end
  end

  // Host strobe history for edge detection.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      host_strobe_prev <= 1'b0;
    end else begin
      host_strobe_prev <= host_step_strobe;
    end
  end

  // Refresh sample of the cursor address.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sampled_col <= cursor_column_pkg::COL_RESET;
      sampled_row <= cursor_column_pkg::ROW_RESET;
    end else if (refresh_start) begin
      sampled_col <= cursor_col_count;
      sampled_row <= cursor_row_count;
    end
  end

  // Control register.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control <= cursor_column_pkg::CONTROL_RESET;
    end else if (bus_write && paddr == cursor_column_pkg::ADDR_CONTROL) begin
      control <= {30'h00000000, pwdata[1:0]};
    end
  end

  // Software step commands wait for the next phase three tick; clear acts on the cycle after the write.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_forward <= 1'b0;
      cmd_backward <= 1'b0;
      cmd_clear <= 1'b0;
    end else begin
      cmd_clear <= bus_write && paddr == cursor_column_pkg::ADDR_COMMAND
        && pwdata[cursor_column_pkg::CMD_CLEAR];
      if (bus_write && paddr == cursor_column_pkg::ADDR_COMMAND
          && pwdata[cursor_column_pkg::CMD_STEP_FORWARD]) begin
        cmd_forward <= 1'b1;
      end else if (phase_three_tick) begin
        cmd_forward <= 1'b0;
      end
      if (bus_write && paddr == cursor_column_pkg::ADDR_COMMAND
          && pwdata[cursor_column_pkg::CMD_STEP_BACKWARD]) begin
        cmd_backward <= 1'b1;
      end else if (phase_three_tick) begin
        cmd_backward <= 1'b0;
      end
    end
  end

  // Read mux.
  always_comb begin
    status_word = 32'h00000000;
    status_word[cursor_column_pkg::STAT_COL_LSB +: 7] = cursor_col_count;
    status_word[cursor_column_pkg::STAT_ROW_LSB +: 5] = cursor_row_count;
    status_word[cursor_column_pkg::STAT_AT_FIRST] = col_at_first;
    status_word[cursor_column_pkg::STAT_AT_LAST] = col_at_last;
    status_word[cursor_column_pkg::STAT_ROW_FIRST] = row_at_first;
    status_word[cursor_column_pkg::STAT_ROW_LAST] = row_at_last;
    status_word[cursor_column_pkg::STAT_HOME] = home;
    read_word = 32'h00000000;
    read_hit = 1'b1;
    case (paddr)
      cursor_column_pkg::ADDR_CONTROL: read_word = control;
      cursor_column_pkg::ADDR_COMMAND: read_word = 32'h00000000;
      cursor_column_pkg::ADDR_STATUS: read_word = status_word;
      cursor_column_pkg::ADDR_SAMPLE: begin
        read_word[cursor_column_pkg::SAMP_COL_LSB +: 7] = sampled_col;
        read_word[cursor_column_pkg::SAMP_ROW_LSB +: 5] = sampled_row;
      end
      default: read_hit = 1'b0;
    endcase
  end

  // Answer every access one cycle after setup.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= bus_setup;
      pslverr <= bus_setup && !read_hit;
      if (bus_setup && !pwrite) begin
        prdata <= read_word;
      end
    end
  end

endmodule // cursor_column_address_logic

// ---- cursor_column_monitor.sv ----
// Checker for the cursor column block, watching only its ports.
// Assumes it is bound to the block and that bus commands never meet pin steps in one cycle.
`timescale 1ns/1ps
module cursor_column_monitor (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Inputs.
  input wire logic seq_col_forward,
  input wire logic seq_col_backward,
  input wire logic phase_three_tick,
  input wire logic sequencer_step_four,
  input wire logic col_clear_n,
  input wire logic key_col_right,
  input wire logic key_col_left,
  input wire logic host_step_strobe,
  input wire logic host_col_load_strobe,
  input wire logic coin_transfer_strobe,
  input wire logic [6:0] col_preset_bits,
  input wire logic refresh_start,
  // Outputs.
  input wire logic [6:0] cursor_col_count,
  input wire logic [6:0] cursor_col_count_n,
  input wire logic [6:0] sampled_col,
  input wire logic col_at_first,
  input wire logic col_at_last,
  input wire logic row_at_first,
  input wire logic home,
  input wire logic tone_trigger,
  input wire logic count_up_enable,
  input wire logic count_down_enable,
  input wire logic wrap_load,
  input wire logic step_pulse,
  input wire logic row_inc_req,
  input wire logic row_dec_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic quiet;
  assign quiet = col_clear_n && !host_col_load_strobe && !coin_transfer_strobe
    && !host_step_strobe && !key_col_right && !key_col_left;
  inv_out_a: assert property (cursor_col_count_n == ~cursor_col_count)
    else $error("inverted column mismatch");
  col_decode_a: assert property (col_at_first == (cursor_col_count == 7'h00)
    && col_at_last == (cursor_col_count == 7'h49)) else $error("column decode mismatch");
  home_flag_a: assert property (home == (col_at_first && row_at_first))
    else $error("home decode mismatch");
  tone_bit_a: assert property (tone_trigger == cursor_col_count[6])
    else $error("tone output mismatch");
  seq_forward_a: assert property (quiet && phase_three_tick && seq_col_forward
    && !seq_col_backward && !col_at_last |=> step_pulse && count_up_enable
    && cursor_col_count == $past(cursor_col_count) + 7'h01) else $error("forward step wrong");
  back_step_a: assert property (quiet && phase_three_tick && seq_col_backward
    && !seq_col_forward && !col_at_first |=> step_pulse && count_down_enable
    && cursor_col_count == $past(cursor_col_count) - 7'h01) else $error("backward step wrong");
  forward_wrap_a: assert property (quiet && phase_three_tick && seq_col_forward
    && !seq_col_backward && col_at_last |=> cursor_col_count == 7'h00 && row_inc_req
    && wrap_load)
    else $error("forward wrap wrong");
  backward_wrap_a: assert property (quiet && phase_three_tick && seq_col_backward
    && !seq_col_forward && col_at_first |=> cursor_col_count == 7'h49 && row_dec_req
    && wrap_load)
    else $error("backward wrap wrong");
  key_hold_a: assert property (key_col_right && !key_col_left && col_clear_n
    && !host_col_load_strobe && !coin_transfer_strobe && !phase_three_tick && !host_step_strobe
    && (col_at_last || !sequencer_step_four) |=> $stable(cursor_col_count))
    else $error("key move not held");
  col_clear_a: assert property (!col_clear_n |=> cursor_col_count == 7'h00)
    else $error("clear failed");
  col_preset_a: assert property (col_clear_n && (host_col_load_strobe
    || coin_transfer_strobe) |=> cursor_col_count == ~$past(col_preset_bits))
    else $error("preset failed");
  sample_col_a: assert property (refresh_start |=> sampled_col == $past(cursor_col_count))
    else $error("sample failed");
  cover property (row_inc_req);
  cover property (row_dec_req);
  cover property (count_down_enable);
  cover property (host_col_load_strobe);
endmodule // cursor_column_monitor

bind cursor_column_address_logic cursor_column_monitor u_cursor_column_monitor (.*);

// ---- cursor_sequencer_model.sv ----
// Model of the sequencer timing and decision logic beside the cursor column block.
// Assumes one system clock; the phase counter runs freely out of reset.
`timescale 1ns/1ps
module cursor_sequencer_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Key and host-link events.
  input wire logic key_left_press,
  input wire logic host_backspace_seen,
  // Timing and moves to the block.
  output logic phase_three_tick,
  output logic sequencer_step_four,
  output logic key_col_left
);
  logic [2:0] phase;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end
  assign phase_three_tick = (phase == 3'h3);
  assign sequencer_step_four = (phase == 3'h4);
  // A received backspace reaches the block only as a left move.
  assign key_col_left = key_left_press || host_backspace_seen;
endmodule // cursor_sequencer_model

// ---- test_cursor_column_address_logic.sv ----
// Self-checking bench for the cursor column block and its sequencer model.
// Assumes the checker binds itself to the block.
`timescale 1ns/1ps
module test_cursor_column_address_logic;
  typedef struct {logic [2:0] kind; logic [6:0] val; logic [6:0] col; logic [4:0] row;} case_type;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, refresh_start = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic seq_col_forward = 1'b0, seq_col_backward = 1'b0, col_clear_n = 1'b1;
  logic key_col_right = 1'b0, key_left_press = 1'b0, host_backspace_seen = 1'b0;
  logic host_col_advance = 1'b0, host_step_strobe = 1'b0, host_col_load_strobe = 1'b0;
  logic coin_transfer_strobe = 1'b0;
  logic [6:0] col_preset_bits = 7'h7F;
  logic [31:0] prdata;
  logic pready, pslverr, phase_three_tick, sequencer_step_four, key_col_left;
  logic [6:0] cursor_col_count, cursor_col_count_n, sampled_col;
  logic [4:0] cursor_row_count, sampled_row;
  logic col_at_first, col_at_last, row_at_first, row_at_last, home, tone_trigger;
  logic count_up_enable, count_down_enable, step_pulse, wrap_load, row_inc_req, row_dec_req;
  int n_errors = 0;
  int tests_run = 0;
  // Kinds: clear, preset, sequencer forward, back, key right, key left, host step, backspace.
  case_type cases [13] = '{'{3'h1, 7'h49, 7'h49, 5'h00}, '{3'h2, 7'h00, 7'h00, 5'h01},
    '{3'h3, 7'h00, 7'h49, 5'h00}, '{3'h4, 7'h00, 7'h49, 5'h00}, '{3'h5, 7'h00, 7'h48, 5'h00},
    '{3'h6, 7'h00, 7'h49, 5'h00}, '{3'h6, 7'h00, 7'h00, 5'h01}, '{3'h7, 7'h00, 7'h00, 5'h01},
    '{3'h2, 7'h00, 7'h01, 5'h01}, '{3'h7, 7'h00, 7'h00, 5'h01}, '{3'h1, 7'h40, 7'h40, 5'h01},
    '{3'h3, 7'h00, 7'h3F, 5'h01}, '{3'h0, 7'h00, 7'h00, 5'h01}};
  cursor_column_address_logic u_cursor_column_address_logic (.*);
  cursor_sequencer_model u_cursor_sequencer_model (.*);
  always #10 clock = ~clock;
  function automatic logic [31:0] state(input logic [6:0] c, input logic [4:0] r);
    return {6'h00, ~c, c[6], c == 7'h00 && r == 5'h00, r == 5'h1A, r == 5'h00, c == 7'h49,
      c == 7'h00, 1'b0, r, c};
  endfunction
  function automatic logic [31:0] got_state();
    return {6'h00, cursor_col_count_n, tone_trigger, home, row_at_last, row_at_first,
      col_at_last, col_at_first, 1'b0, cursor_row_count, cursor_col_count};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata | {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic act(input logic [2:0] k, input logic [6:0] v);
    @(posedge clock);
    case (k)
      3'h0: col_clear_n <= 1'b0;
      3'h1: begin
        col_preset_bits <= ~v;
        host_col_load_strobe <= 1'b1;
      end
      3'h2: seq_col_forward <= 1'b1;
      3'h3: seq_col_backward <= 1'b1;
      3'h6: host_col_advance <= 1'b1;
      default: begin
        while (phase_three_tick !== 1'b1) @(posedge clock);
        key_col_right <= (k == 3'h4);
        key_left_press <= (k == 3'h5);
        host_backspace_seen <= (k == 3'h7);
      end
    endcase
    @(posedge clock);
    host_step_strobe <= (k == 3'h6);
    for (int i = 0; i < 20 && (k == 3'h2 || k == 3'h3) && step_pulse !== 1'b1; i++) begin
      @(posedge clock);
    end
    col_clear_n <= 1'b1;
    host_col_load_strobe <= 1'b0;
    seq_col_forward <= 1'b0;
    seq_col_backward <= 1'b0;
    key_col_right <= 1'b0;
    key_left_press <= 1'b0;
    host_backspace_seen <= 1'b0;
    @(posedge clock);
    host_step_strobe <= 1'b0;
    host_col_advance <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic complete_run();
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  initial begin
    logic [31:0] rd;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    check(got_state(), state(7'h00, 5'h00));
    foreach (cases[i]) begin
      act(cases[i].kind, cases[i].val);
      check(got_state(), state(cases[i].col, cases[i].row));
    end
    @(posedge clock);
    col_clear_n <= 1'b0;
    host_col_load_strobe <= 1'b1;
    col_preset_bits <= ~7'h20;
    @(posedge clock);
    col_clear_n <= 1'b1;
    host_col_load_strobe <= 1'b0;
    @(posedge clock);
    check(got_state(), state(7'h00, 5'h01));
    apb(1'b1, cursor_column_pkg::ADDR_CONTROL, 32'h00000002, rd);
    apb(1'b0, cursor_column_pkg::ADDR_CONTROL, 32'h00000000, rd);
    check(rd, 32'h00000002);
    apb(1'b1, cursor_column_pkg::ADDR_CONTROL, 32'h00000000, rd);
    apb(1'b0, cursor_column_pkg::ADDR_STATUS, 32'h00000000, rd);
    check(rd, 32'h00010100);
    apb(1'b0, 8'h10, 32'h00000000, rd);
    check(rd, 32'h00000001);
    @(posedge clock);
    coin_transfer_strobe <= 1'b1;
    col_preset_bits <= ~7'h15;
    @(posedge clock);
    coin_transfer_strobe <= 1'b0;
    @(posedge clock);
    check(got_state(), state(7'h15, 5'h01));
    apb(1'b1, cursor_column_pkg::ADDR_COMMAND, 32'h00000001, rd);
    repeat (10) @(posedge clock);
    check(got_state(), state(7'h16, 5'h01));
    apb(1'b1, cursor_column_pkg::ADDR_CONTROL, 32'h00000001, rd);
    apb(1'b1, cursor_column_pkg::ADDR_COMMAND, 32'h00000002, rd);
    repeat (10) @(posedge clock);
    check(got_state(), state(7'h16, 5'h01));
    apb(1'b1, cursor_column_pkg::ADDR_CONTROL, 32'h00000000, rd);
    apb(1'b1, cursor_column_pkg::ADDR_COMMAND, 32'h00000004, rd);
    repeat (2) @(posedge clock);
    check(got_state(), state(7'h00, 5'h01));
    apb(1'b0, cursor_column_pkg::ADDR_COMMAND, 32'h00000000, rd);
    check(rd, 32'h00000000);
    act(3'h1, 7'h2A);
    @(posedge clock);
    refresh_start <= 1'b1;
    @(posedge clock);
    refresh_start <= 1'b0;
    act(3'h0, 7'h00);
    apb(1'b0, cursor_column_pkg::ADDR_SAMPLE, 32'h00000000, rd);
    check(rd, 32'h0000012A);
    repeat (27) begin
      act(3'h1, 7'h49);
      act(3'h6, 7'h00);
    end
    check(got_state(), state(7'h00, 5'h1A));
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    check(got_state(), state(7'h00, 5'h00));
    complete_run();
  end
endmodule // test_cursor_column_address_logic
